/* File: shared/branch_unit_pkg.sv */
package branch_unit_pkg;

  localparam int unsigned XLEN      = 32;
  localparam int unsigned ADDR_W    = 8;

  // Primary and extended opcodes
  localparam logic [5:0] OPC_UNCOND = 6'h12;
  localparam logic [5:0] OPC_COND   = 6'h10;
  localparam logic [5:0] OPC_XL     = 6'h13;
  localparam logic [9:0] XO_TO_COUNT = 10'h210;

  // Instruction field positions, little-endian bit indices
  localparam int unsigned OPC_LSB = 26;
  localparam int unsigned OPT_LSB = 21;
  localparam int unsigned CS_LSB  = 16;
  localparam int unsigned SD_LSB  = 2;
  localparam int unsigned LD_LSB  = 2;
  localparam int unsigned XO_LSB  = 1;
  localparam int unsigned ABS_BIT = 1;
  localparam int unsigned LNK_BIT = 0;
  localparam int unsigned LD_W    = 24;
  localparam int unsigned SD_W    = 14;

  // Bits of the branch_options field, little-endian
  localparam int unsigned OP_IGN_COND  = 4;
  localparam int unsigned OP_COND_TRUE = 3;
  localparam int unsigned OP_NO_DEC    = 2;
  localparam int unsigned OP_ZERO      = 1;
  localparam int unsigned OP_HINT      = 0;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_COUNT      = 8'h04;
  localparam logic [7:0] OFS_LINK       = 8'h08;
  localparam logic [7:0] OFS_COND       = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_TARGET     = 8'h14;
  localparam logic [7:0] OFS_TAKEN_CNT  = 8'h18;
  localparam logic [7:0] OFS_INVAL_CNT  = 8'h1C;

  // Field positions in control and status
  localparam int unsigned CTRL_OLDER   = 0;
  localparam int unsigned ST_TAKEN     = 0;
  localparam int unsigned ST_INVALID   = 1;
  localparam int unsigned ST_HINT      = 2;
  localparam int unsigned ST_DECR      = 3;
  localparam int unsigned ST_LINKED    = 4;
  localparam int unsigned ST_BRANCH    = 5;

  // Reset values and other word constants
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] LINK_RST  = 32'h0000_0000;
  localparam logic [31:0] COND_RST  = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
  localparam logic [31:0] ONE_WORD  = 32'h0000_0001;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_UNCOND,
    KIND_COND,
    KIND_TO_COUNT
  } branch_kind_t;

endpackage

/* File: shared/branch_eval_if.sv */
interface branch_eval_if;
  import branch_unit_pkg::*;

  logic [4:0]  branch_options;
  logic        cond_bit;
  logic [31:0] count;
  logic        older_variant;
  logic        to_count;
  logic        taken;
  logic        decrement;
  logic [31:0] count_next;
  logic        invalid;
  logic        hint;

  modport evaluator (
    input  branch_options, cond_bit, count, older_variant, to_count,
    output taken, decrement, count_next, invalid, hint
  );

  modport requester (
    output branch_options, cond_bit, count, older_variant, to_count,
    input  taken, decrement, count_next, invalid, hint
  );

endinterface

/* File: logic/branch_condition_eval.sv */
module branch_condition_eval
  import branch_unit_pkg::*;
(
  branch_eval_if.evaluator e
);

  logic [4:0] op;
  logic       z_set;
  logic       ctr_ok;
  logic       cond_ok;
  logic       always_form;

  assign op = e.branch_options;

  always_comb begin
    e.decrement  = ~op[OP_NO_DEC];
    e.count_next = e.decrement ? e.count - ONE_WORD : e.count;
    ctr_ok  = ~e.decrement | ((e.count_next == ZERO_WORD) == op[OP_ZERO]);
    cond_ok = op[OP_IGN_COND] | (e.cond_bit == op[OP_COND_TRUE]);
    always_form = op[OP_IGN_COND] & op[OP_NO_DEC];
    // Positions that must be zero depend on the form
    z_set = 1'b0;
    if (!op[OP_IGN_COND]) begin
      if (op[OP_NO_DEC]) begin
        z_set = op[OP_ZERO];
      end
    end else begin
      z_set = op[OP_COND_TRUE];
      if (op[OP_NO_DEC]) begin
        z_set = op[OP_COND_TRUE] | op[OP_ZERO] | op[OP_HINT];
      end
    end
    e.taken   = always_form | (ctr_ok & cond_ok);
    e.invalid = (z_set & ~e.older_variant)
              | (e.to_count & e.decrement);
    // Hint is carried only; it never steers the outcome
    e.hint    = always_form ? 1'b0 : op[OP_HINT];
  end

endmodule

/* File: logic/branch_target_condition_unit.sv */
// Overview of operation
// - Relative long branch: displacement with two zero bits, sign-extended, plus address.
// - Absolute long branch: displacement with two zero bits, sign-extended, used directly.
// - Relative conditional branch: short displacement shifted, sign-extended, plus address.
// - Absolute conditional branch: short displacement shifted and sign-extended is target.
// - Branch to count register targets its upper thirty bits with two zeros.
// - Link select set writes next sequential address to link register, else unchanged.
// - No branch variant ever changes exception register or condition field zero.
// - Codes 0000y/0001y decrement count; need false condition and count nonzero/zero.
// - Codes 0100y/0101y decrement count; need true condition and count nonzero/zero.
// - Codes 1z00y/1z01y decrement count and branch on nonzero/zero count only.
// - Codes 001zy/011zy keep count, branch on false/true condition; 1z1zz always.
// - Condition bit select field picks one condition register bit to test.
// - Newer variant flags any nonzero z position as an invalid form.
// - The y position is only a prediction hint; either value accepted.
// - Older variant accepts any z and y values as valid.
module branch_target_condition_unit
  import branch_unit_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,

  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,

  // Instruction from fetch
  input  wire logic              instr_valid,
  input  wire logic [31:0]       instr_word,
  input  wire logic [31:0]       instr_addr,

  // Resolution to sequencing
  output logic                   res_valid,
  output logic                   res_branch,
  output logic                   res_taken,
  output logic                   res_invalid,
  output logic                   res_hint,
  output logic                   res_link_write,
  output logic      [31:0]       res_target,
  output logic      [31:0]       res_next_addr
);

  branch_eval_if ev ();

  // Decoded fields
  logic [5:0]       opcode;
  logic [9:0]       ext_opcode;
  logic [4:0]       branch_options;
  logic [4:0]       condition_bit_select;
  logic [LD_W-1:0]  long_displacement;
  logic [SD_W-1:0]  short_displacement;
  logic             absolute_select;
  logic             link_select;
  branch_kind_t     kind;

  // Architectural state
  logic [31:0]      ctrl_q;
  logic [31:0]      count_register_q;
  logic [31:0]      link_q;
  logic [31:0]      cond_q;
  logic [31:0]      cond_be;

  // Result and status state
  logic             res_valid_q;
  logic             res_branch_q;
  logic             res_taken_q;
  logic             res_invalid_q;
  logic             res_hint_q;
  logic             res_link_q;
  logic             res_decr_q;
  logic [31:0]      res_target_q;
  logic [31:0]      res_next_q;
  logic [31:0]      taken_cnt_q;
  logic [31:0]      inval_cnt_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;

  // Computed per instruction
  logic [31:0]      long_ext;
  logic [31:0]      short_ext;
  logic [31:0]      count_target;
  logic [31:0]      seq_addr;
  logic [31:0]      target_d;
  logic             taken_d;
  logic             invalid_d;
  logic             hint_d;
  logic             decr_d;
  logic             link_d;
  logic             accept;

  // Field extraction, bit 0 of the instruction is its least significant bit
  assign opcode               = instr_word[OPC_LSB +: 6];
  assign ext_opcode           = instr_word[XO_LSB +: 10];
  assign branch_options       = instr_word[OPT_LSB +: 5];
  assign condition_bit_select = instr_word[CS_LSB +: 5];
  assign long_displacement    = instr_word[LD_LSB +: LD_W];
  assign short_displacement   = instr_word[SD_LSB +: SD_W];
  assign absolute_select      = instr_word[ABS_BIT];
  assign link_select          = instr_word[LNK_BIT];

  always_comb begin
    case (opcode)
      OPC_UNCOND: begin
        kind = KIND_UNCOND;
      end
      OPC_COND: begin
        kind = KIND_COND;
      end
      OPC_XL: begin
        kind = (ext_opcode == XO_TO_COUNT) ? KIND_TO_COUNT : KIND_NONE;
      end
      default: begin
        kind = KIND_NONE;
      end
    endcase
  end

  // Condition register seen in big-endian bit numbering
  genvar g;
  generate
    for (g = 0; g < XLEN; g++) begin : g_cond_order
      assign cond_be[g] = cond_q[XLEN-1-g];
    end
  endgenerate

  // Condition evaluation
  assign ev.branch_options = branch_options;
  assign ev.cond_bit       = cond_be[condition_bit_select];
  assign ev.count          = count_register_q;
  assign ev.older_variant  = ctrl_q[CTRL_OLDER];
  assign ev.to_count       = (kind == KIND_TO_COUNT);

  branch_condition_eval u_eval (
    .e (ev)
  );

  // Target formation
  assign long_ext     = {{6{long_displacement[LD_W-1]}}, long_displacement, 2'b00};
  assign short_ext    = {{16{short_displacement[SD_W-1]}}, short_displacement, 2'b00};
  assign count_target = {count_register_q[31:2], 2'b00};
  assign seq_addr     = instr_addr + INSTR_STEP;

  always_comb begin
    target_d  = seq_addr;
    taken_d   = 1'b0;
    invalid_d = 1'b0;
    hint_d    = 1'b0;
    decr_d    = 1'b0;
    case (kind)
      KIND_UNCOND: begin
        taken_d = 1'b1;
        if (absolute_select) begin
          target_d = long_ext;
        end else begin
          target_d = instr_addr + long_ext;
        end
      end
      KIND_COND: begin
        taken_d   = ev.taken;
        invalid_d = ev.invalid;
        hint_d    = ev.hint;
        decr_d    = ev.decrement;
        if (absolute_select) begin
          target_d = short_ext;
        end else begin
          target_d = instr_addr + short_ext;
        end
      end
      KIND_TO_COUNT: begin
        taken_d   = ev.taken;
        invalid_d = ev.invalid;
        hint_d    = ev.hint;
        decr_d    = ev.decrement;
        target_d  = count_target;
      end
      default: begin
        target_d  = seq_addr;
      end
    endcase
  end

  // Invalid forms have no architectural effect
  assign accept = instr_valid & (kind != KIND_NONE) & ~invalid_d;
  assign link_d = accept & link_select;

  // Control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      ctrl_q <= {31'h0000_0000, reg_wdata[CTRL_OLDER]};
    end
  end

  // Count register; a decrement in the same cycle wins over software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_register_q <= COUNT_RST;
    end else if (accept && decr_d) begin
      count_register_q <= ev.count_next;
    end else if (reg_wr && reg_addr == OFS_COUNT) begin
      count_register_q <= reg_wdata;
    end
  end

  // Link register; left alone when link select is clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= LINK_RST;
    end else if (link_d) begin
      link_q <= seq_addr;
    end else if (reg_wr && reg_addr == OFS_LINK) begin
      link_q <= reg_wdata;
    end
  end

  // Condition register is only read by branches, never written by them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_q <= COND_RST;
    end else if (reg_wr && reg_addr == OFS_COND) begin
      cond_q <= reg_wdata;
    end
  end

  // Resolution outputs, one cycle after the instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= instr_valid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_branch_q  <= 1'b0;
      res_taken_q   <= 1'b0;
      res_invalid_q <= 1'b0;
      res_hint_q    <= 1'b0;
      res_link_q    <= 1'b0;
      res_decr_q    <= 1'b0;
      res_target_q  <= ZERO_WORD;
      res_next_q    <= ZERO_WORD;
    end else if (instr_valid) begin
      res_branch_q  <= (kind != KIND_NONE);
      res_taken_q   <= accept & taken_d;
      res_invalid_q <= invalid_d;
      res_hint_q    <= hint_d;
      res_link_q    <= link_d;
      res_decr_q    <= accept & decr_d;
      res_target_q  <= target_d;
      res_next_q    <= (accept && taken_d) ? target_d : seq_addr;
    end
  end

  // Event counters; writing the offset clears, a same-cycle event still counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_cnt_q <= ZERO_WORD;
    end else if (reg_wr && reg_addr == OFS_TAKEN_CNT) begin
      taken_cnt_q <= (accept && taken_d) ? ONE_WORD : ZERO_WORD;
    end else if (accept && taken_d) begin
      taken_cnt_q <= taken_cnt_q + ONE_WORD;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inval_cnt_q <= ZERO_WORD;
    end else if (reg_wr && reg_addr == OFS_INVAL_CNT) begin
      inval_cnt_q <= (instr_valid && invalid_d) ? ONE_WORD : ZERO_WORD;
    end else if (instr_valid && invalid_d) begin
      inval_cnt_q <= inval_cnt_q + ONE_WORD;
    end
  end

  // Read path
  always_comb begin
    rdata_d = ZERO_WORD;
    case (reg_addr)
      OFS_CTRL: begin
        rdata_d = ctrl_q;
      end
      OFS_COUNT: begin
        rdata_d = count_register_q;
      end
      OFS_LINK: begin
        rdata_d = link_q;
      end
      OFS_COND: begin
        rdata_d = cond_q;
      end
      OFS_STATUS: begin
        rdata_d[ST_TAKEN]   = res_taken_q;
        rdata_d[ST_INVALID] = res_invalid_q;
        rdata_d[ST_HINT]    = res_hint_q;
        rdata_d[ST_DECR]    = res_decr_q;
        rdata_d[ST_LINKED]  = res_link_q;
        rdata_d[ST_BRANCH]  = res_branch_q;
      end
      OFS_TARGET: begin
        rdata_d = res_target_q;
      end
      OFS_TAKEN_CNT: begin
        rdata_d = taken_cnt_q;
      end
      OFS_INVAL_CNT: begin
        rdata_d = inval_cnt_q;
      end
      default: begin
        rdata_d = ZERO_WORD;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= ZERO_WORD;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= ZERO_WORD;
    end
  end

  assign reg_rdata      = rdata_q;
  assign res_valid      = res_valid_q;
  assign res_branch     = res_branch_q;
  assign res_taken      = res_taken_q;
  assign res_invalid    = res_invalid_q;
  assign res_hint       = res_hint_q;
  assign res_link_write = res_link_q;
  assign res_target     = res_target_q;
  assign res_next_addr  = res_next_q;

endmodule

/* File: tb/fetch_model.sv */
module fetch_model (
  // Clock
  input  wire logic        clk,
  // Instruction to the unit
  output logic             instr_valid,
  output logic [31:0]      instr_word,
  output logic [31:0]      instr_addr,
  // Resolution back
  input  wire logic        res_valid,
  input  wire logic        res_taken
);
  timeunit 1ns;
  timeprecision 1ns;

  logic tk_q[$];

  initial begin
    instr_valid = 1'h0;
    instr_word  = 32'h0000_0000;
    instr_addr  = 32'h0000_0000;
  end

  // Log every resolution so back-to-back results can be judged later
  always @(posedge clk) begin
    if (res_valid === 1'h1) begin
      tk_q.push_back(res_taken);
    end
  end

  // Issue one word for n consecutive cycles, then show a garbled idle word
  task automatic send(input logic [31:0] w, input logic [31:0] a, input int n);
    @(posedge clk);
    instr_valid <= 1'h1;
    instr_word  <= w;
    instr_addr  <= a;
    repeat (n) @(posedge clk);
    instr_valid <= 1'h0;
    instr_word  <= ~w;
    instr_addr  <= ~a;
  endtask
endmodule

/* File: tb/branch_target_condition_unit_checker.sv */
module branch_target_condition_unit_checker
  import branch_unit_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  // Instruction and resolution
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] instr_addr,
  input  wire logic        res_valid,
  input  wire logic        res_taken,
  input  wire logic        res_invalid,
  input  wire logic        res_link_write,
  input  wire logic [31:0] res_target,
  input  wire logic [31:0] res_next_addr
);
  logic [5:0]  opc;
  logic        abs_sel;
  logic        lnk_sel;
  logic [31:0] long_ofs;
  logic [31:0] short_ofs;
  assign opc       = instr_word[31:26];
  assign abs_sel   = instr_word[1];
  assign lnk_sel   = instr_word[0];
  assign long_ofs  = {{6{instr_word[25]}}, instr_word[25:2], 2'h0};
  assign short_ofs = {{16{instr_word[15]}}, instr_word[15:2], 2'h0};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_long;
    instr_valid && opc == OPC_UNCOND;
  endsequence
  sequence s_cond_always;
    instr_valid && opc == OPC_COND && instr_word[25:21] == 5'h14;
  endsequence

  valid_pulse_a: assert property (instr_valid |=> res_valid)
    else $error("result strobe missing");
  valid_only_a: assert property (!instr_valid |=> !res_valid)
    else $error("result strobe without instruction");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == ZERO_WORD)
    else $error("read data not zero outside read cycle");
  long_rel_a:
    assert property (s_long ##0 !abs_sel |=> res_target == $past(instr_addr) + $past(long_ofs))
    else $error("relative long target wrong");
  long_abs_a:
    assert property (s_long ##0 abs_sel |=> res_taken && res_target == $past(long_ofs))
    else $error("absolute long target wrong");
  cond_target_a:
    assert property (s_cond_always |=> res_taken && res_target ==
      ($past(abs_sel) ? ZERO_WORD : $past(instr_addr)) + $past(short_ofs))
    else $error("conditional target wrong");
  long_link_a:
    assert property (s_long |=> res_link_write == $past(lnk_sel))
    else $error("link write does not follow link select");
  invalid_quiet_a:
    assert property (res_valid && res_invalid |-> !res_taken && !res_link_write)
    else $error("invalid form had an effect");
  fall_through_a: assert property (res_valid && !res_taken |->
      res_next_addr == $past(instr_addr) + INSTR_STEP)
    else $error("sequential address wrong");
  taken_next_a: assert property (res_valid && res_taken |-> res_next_addr == res_target)
    else $error("taken branch does not go to target");
  result_hold_a: assert property (!instr_valid |=> $stable(res_target) && $stable(res_taken))
    else $error("result changed without instruction");
endmodule

bind branch_target_condition_unit branch_target_condition_unit_checker
  u_branch_target_condition_unit_checker (
  .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr),
  .res_valid(res_valid), .res_taken(res_taken), .res_invalid(res_invalid),
  .res_link_write(res_link_write), .res_target(res_target), .res_next_addr(res_next_addr));

/* File: tb/tb_branch_target_condition_unit.sv */
module tb_branch_target_condition_unit
  import branch_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              instr_valid;
  logic [31:0]       instr_word;
  logic [31:0]       instr_addr;
  logic              res_valid, res_branch, res_taken, res_invalid, res_hint, res_link_write;
  logic [31:0]       res_target;
  logic [31:0]       res_next_addr;
  int                bad_count;
  int                n_compared;
  // Branch options per case: expected taken and condition level are bit vectors
  logic [4:0]  op_t [11] = '{5'h00, 5'h02, 5'h08, 5'h0A, 5'h10, 5'h12, 5'h04, 5'h0C,
                             5'h14, 5'h09, 5'h00};
  logic [10:0] tk_t = 11'h39B;
  logic [10:0] cd_t = 11'h6CC;

  branch_target_condition_unit u_branch_target_condition_unit (.*);
  fetch_model fetch (.clk(clk), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_addr(instr_addr), .res_valid(res_valid), .res_taken(res_taken));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic test_done;
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'h0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'h0;
    @(negedge clk);
    chk(n, e, reg_rdata);
  endtask

  task automatic exec(input logic [31:0] w, input logic [31:0] a);
    fetch.send(w, a, 1);
    @(negedge clk);
    chk("res_valid", 32'h1, res_valid);
  endtask

  function automatic logic [31:0] cond_word(input logic [4:0] opts, input logic abs_sel,
    input logic lnk_sel);
    return {OPC_COND, opts, 5'h07, 14'h2001, abs_sel, lnk_sel};
  endfunction

  function automatic logic [31:0] count_word(input logic [4:0] opts);
    return {OPC_XL, opts, 5'h07, 5'h00, XO_TO_COUNT, 1'h1};
  endfunction

  task automatic t_regs;
    rd(OFS_CTRL, CTRL_RST, "ctrl");
    rd(OFS_COUNT, COUNT_RST, "count");
    rd(OFS_LINK, LINK_RST, "link");
    rd(OFS_COND, COND_RST, "cond");
    rd(8'h20, ZERO_WORD, "unmapped");
    wr(OFS_COND, 32'hA5A5_0000);
    rd(OFS_COND, 32'hA5A5_0000, "cond");
  endtask

  task automatic t_uncond;
    logic [31:0] a;
    logic [31:0] t;
    a = 32'h0000_1000;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_LINK, 32'h0000_0044);
      exec({OPC_UNCOND, 24'h80_0001, i[1], i[0]}, a);
      chk("branch", 32'h1, res_branch);
      t = i[1] ? 32'hFE00_0004 : a + 32'hFE00_0004;
      chk("target", t, res_target);
      chk("link_write", i[0], res_link_write);
      rd(OFS_LINK, i[0] ? a + INSTR_STEP : 32'h0000_0044, "link");
      rd(OFS_COND, 32'hA5A5_0000, "cond");
    end
    rd(OFS_TARGET, t, "target_reg");
  endtask

  task automatic t_cond;
    logic [31:0] a;
    logic [31:0] n;
    logic [31:0] t;
    a = 32'h0000_4000;
    for (int i = 0; i < 11; i++) begin
      n = (i inside {1, 2, 3}) ? 32'h1 : (i == 9) ? 32'h3 : 32'h2;
      wr(OFS_COUNT, n);
      wr(OFS_COND, cd_t[i] ? 32'h0100_0000 : 32'hFEFF_FFFF);
      exec(cond_word(op_t[i], i[0], i[1]), a);
      t = (i[0] ? ZERO_WORD : a) + 32'hFFFF_8004;
      chk("taken", tk_t[i], res_taken);
      chk("target", t, res_target);
      chk("next", tk_t[i] ? t : a + INSTR_STEP, res_next_addr);
      chk("hint", op_t[i][0], res_hint);
      chk("link_write", i[1], res_link_write);
      rd(OFS_COUNT, op_t[i][2] ? n : n - 32'h1, "count");
    end
  endtask

  task automatic t_inval;
    logic [31:0] a;
    a = 32'h0000_8000;
    wr(OFS_COUNT, 32'h1234_5677);
    wr(OFS_LINK, ZERO_WORD);
    wr(OFS_COND, 32'hFEFF_FFFF);
    wr(OFS_INVAL_CNT, ZERO_WORD);
    for (int v = 0; v < 2; v++) begin
      wr(OFS_CTRL, 32'(v));
      exec(cond_word(5'h06, 1'h0, 1'h1), a);
      chk("invalid", v == 0, res_invalid);
      chk("taken", v[0], res_taken);
      rd(OFS_LINK, v[0] ? a + INSTR_STEP : ZERO_WORD, "link");
      exec(count_word(5'h00), a);
      chk("invalid", 32'h1, res_invalid);
      rd(OFS_COUNT, 32'h1234_5677, "count");
    end
    exec(count_word(5'h1F), a);
    chk("target", 32'h1234_5674, res_target);
    wr(OFS_CTRL, CTRL_RST);
    exec(count_word(5'h14), a);
    chk("taken", 32'h1, res_taken);
    chk("invalid", 32'h0, res_invalid);
    rd(OFS_STATUS, 32'h0000_0031, "status");
    rd(OFS_INVAL_CNT, 32'h0000_0003, "invalid_count");
  endtask

  task automatic t_back;
    wr(OFS_COUNT, 32'h2);
    wr(OFS_TAKEN_CNT, ZERO_WORD);
    fetch.send(cond_word(5'h10, 1'h0, 1'h0), 32'h0000_0100, 2);
    @(posedge clk);
    #1;
    chk("first_taken", 32'h1, fetch.tk_q[$-1]);
    chk("second_taken", 32'h0, fetch.tk_q[$]);
    rd(OFS_COUNT, ZERO_WORD, "count");
    exec(32'h7C00_0000, 32'h0000_0200);
    chk("branch", 32'h0, res_branch);
    exec({OPC_XL, 5'h14, 10'h000, 10'h010, 1'h1}, 32'h0000_0300);
    chk("branch", 32'h0, res_branch);
    chk("link_write", 32'h0, res_link_write);
    rd(OFS_TAKEN_CNT, ONE_WORD, "taken_count");
  endtask

  initial begin
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0000_0000;
    reg_wr     = 1'h0;
    reg_rd     = 1'h0;
    rst_n      = 1'h0;
    bad_count  = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    t_regs;
    t_uncond;
    t_cond;
    t_inval;
    t_back;
    test_done;
  end

  // Hang guard
  initial begin
    #1_000_000;
    bad_count++;
    test_done;
  end
endmodule
